// ==== rtl/sls_pkg.sv ====
// sls_pkg: constants and types for the status led sequencer
// assumes a 10 MHz system clock; all times are converted to cycles here
package sls_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    // times in milliseconds, as printed or chosen
    localparam int unsigned IDLE_PERIOD_MS = 1000;
    localparam int unsigned POLL_DEF_MS = 5000;
    localparam int unsigned FAST_HALF_MS = 50;
    localparam int unsigned SLOW_HALF_MS = 400;
    localparam int unsigned BLIP_MS = 20;
    localparam int unsigned FAINT_MS = 2;
    localparam int unsigned RANGE_HALF_MS = 5;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned IDLE_HALF_CYC = IDLE_PERIOD_MS * CYC_PER_MS / 2;
    localparam int unsigned POLL_DEF_CYC = POLL_DEF_MS * CYC_PER_MS;
    localparam int unsigned FAST_HALF_CYC = FAST_HALF_MS * CYC_PER_MS;
    localparam int unsigned SLOW_HALF_CYC = SLOW_HALF_MS * CYC_PER_MS;
    localparam int unsigned BLIP_CYC = BLIP_MS * CYC_PER_MS;
    localparam int unsigned FAINT_CYC = FAINT_MS * CYC_PER_MS;
    localparam int unsigned RANGE_HALF_CYC = RANGE_HALF_MS * CYC_PER_MS;
    // flash counts, then timer and flash count widths
    localparam int unsigned BOOT_FLASHES = 10;
    localparam int unsigned RADIO_FLASHES = 4;
    localparam int unsigned FLASH_FLASHES = 5;
    localparam int unsigned NV_FLASHES = 3;
    localparam int unsigned TW = 32;
    localparam int unsigned NW = 4;
    typedef enum logic [5:0] {
        SLS_BOOT  = 6'h01,
        SLS_RUN   = 6'h02,
        SLS_FLASH = 6'h04,
        SLS_BLIP  = 6'h08,
        SLS_FAULT = 6'h10,
        SLS_GAP   = 6'h20
    } sls_state_e;
endpackage

// ==== rtl/sls_status_led.sv ====
// sls_status_led: drives the device status led and three charge leds
// assumes state inputs are levels from on-chip logic on clk_sys; pulse
// inputs are one-cycle strobes; charger inputs are pins, synchronised here
`timescale 1ns/1ns
module sls_status_led
    import sls_pkg::*;
#(
    parameter int unsigned IDLE_HALF = IDLE_HALF_CYC,
    parameter int unsigned FAST_HALF = FAST_HALF_CYC,
    parameter int unsigned SLOW_HALF = SLOW_HALF_CYC,
    parameter int unsigned BLIP_LEN = BLIP_CYC,
    parameter int unsigned FAINT_LEN = FAINT_CYC,
    parameter int unsigned RANGE_HALF = RANGE_HALF_CYC,
    parameter logic [TW-1:0] POLL_DEFAULT = TW'(POLL_DEF_CYC)
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // boot outcome from the controller
    input wire logic boot_done,
    input wire logic radio_fault,
    input wire logic flash_fault,
    // session levels
    input wire logic sess_log,
    input wire logic sess_stream,
    input wire logic sess_hs,
    input wire logic sess_ldc,
    input wire logic range_test,
    input wire logic sleep_mode,
    // event strobes
    input wire logic ldc_sample,
    input wire logic ping_evt,
    input wire logic nv_evt,
    // poll interval programming
    input wire logic poll_wr,
    input wire logic [TW-1:0] poll_val,
    // charger pins
    input wire logic ext_pwr_ok,
    input wire logic chg_active,
    input wire logic batt_full,
    // led drives, active high
    output logic led_status,
    output logic led_pwr_good,
    output logic led_charging,
    output logic led_chg_done
);
    typedef struct packed {
        sls_state_e st;
        logic [TW-1:0] tmr;
        logic [NW-1:0] left;
        logic [TW-1:0] poll;
        logic [TW-1:0] poll_cnt;
        logic [TW-1:0] idle_cnt;
        logic [TW-1:0] rng_cnt;
        logic idle_ph;
        logic rng_ph;
        logic blip_pend;
        logic nv_pend;
        logic slow;
        logic [TW-1:0] blip_len;
        logic [2:0] s1;
        logic [2:0] s2;
        logic status;
        logic pg;
        logic chg;
        logic done;
    } sls_reg_s;

    sls_reg_s q, d;

    // half period used while flashing a counted burst
    function automatic logic [TW-1:0] half_of(input logic slow_f);
        half_of = slow_f ? TW'(SLOW_HALF) : TW'(FAST_HALF);
    endfunction

    // wrap-around step of a free divider
    function automatic logic [TW-1:0] step(input logic [TW-1:0] c,
                                           input logic [TW-1:0] lim);
        step = (c + TW'(1) >= lim) ? '0 : c + TW'(1);
    endfunction

    logic active_on;
    logic flash_start;

    always_comb begin
        d = q;
        active_on = 1'b0;
        flash_start = 1'b0;
        // charger pins pass two flops before use
        d.s1 = {ext_pwr_ok, chg_active, batt_full};
        d.s2 = q.s1;
        d.pg = q.s2[2];
        d.chg = q.s2[2] & q.s2[1] & ~q.s2[0];
        d.done = q.s2[2] & q.s2[1] & q.s2[0];
        if (poll_wr) begin
            d.poll = (poll_val == '0) ? TW'(1) : poll_val;
        end
        d.idle_cnt = step(q.idle_cnt, TW'(IDLE_HALF));
        if (q.idle_cnt + TW'(1) >= TW'(IDLE_HALF)) begin
            d.idle_ph = ~q.idle_ph;
        end
        d.rng_cnt = step(q.rng_cnt, TW'(RANGE_HALF));
        if (q.rng_cnt + TW'(1) >= TW'(RANGE_HALF)) begin
            d.rng_ph = ~q.rng_ph;
        end
        if (sleep_mode) begin
            d.poll_cnt = step(q.poll_cnt, q.poll);
        end else begin
            d.poll_cnt = '0;
        end
        // strobes are latched so a blip during another pattern is not lost
        if (ping_evt || (sess_ldc && ldc_sample)) begin
            d.blip_pend = 1'b1;
        end
        if (nv_evt) begin
            d.nv_pend = 1'b1;
        end
        case (q.st)
            SLS_BOOT: begin
                d.status = 1'b0;
                if (boot_done) begin
                    // faults take precedence over the good pattern
                    if (radio_fault) begin
                        d.left = NW'(RADIO_FLASHES);
                        d.slow = 1'b1;
                        d.st = SLS_FAULT;
                    end else if (flash_fault) begin
                        d.left = NW'(FLASH_FLASHES);
                        d.slow = 1'b1;
                        d.st = SLS_FAULT;
                    end else begin
                        d.left = NW'(BOOT_FLASHES);
                        d.slow = 1'b0;
                        d.st = SLS_FLASH;
                    end
                    d.tmr = '0;
                    d.status = 1'b1;
                end
            end
            SLS_FLASH, SLS_FAULT: begin
                d.tmr = q.tmr + TW'(1);
                if (q.tmr + TW'(1) >= half_of(q.slow)) begin
                    d.tmr = '0;
                    if (q.status) begin
                        d.status = 1'b0;
                        d.left = q.left - NW'(1);
                    end else if (q.left == '0) begin
                        // a faulted boot stays dark after its blinks
                        d.st = (q.st == SLS_FAULT) ? SLS_GAP : SLS_RUN;
                    end else begin
                        d.status = 1'b1;
                    end
                end
            end
            SLS_BLIP: begin
                d.tmr = q.tmr + TW'(1);
                if (q.tmr + TW'(1) >= q.blip_len) begin
                    d.status = 1'b0;
                    d.tmr = '0;
                    d.st = SLS_RUN;
                end
            end
            SLS_GAP: begin
                d.status = 1'b0;
            end
            default: begin
                // SLS_RUN: activity beats idle
                if (q.nv_pend) begin
                    d.nv_pend = nv_evt;
                    flash_start = 1'b1;
                end else if (q.blip_pend) begin
                    d.blip_pend = ping_evt || (sess_ldc && ldc_sample);
                    d.blip_len = TW'(BLIP_LEN);
                    d.st = SLS_BLIP;
                    d.status = 1'b1;
                    d.tmr = '0;
                end else if (sleep_mode && q.poll_cnt == '0 && !sess_ldc
                             && !range_test) begin
                    d.blip_len = TW'(FAINT_LEN);
                    d.st = SLS_BLIP;
                    d.status = 1'b1;
                    d.tmr = '0;
                end else begin
                    if (sess_log || sess_stream || sess_hs) begin
                        active_on = 1'b1;
                    end else if (range_test) begin
                        active_on = q.rng_ph;
                    end else if (sess_ldc || sleep_mode) begin
                        active_on = 1'b0;
                    end else begin
                        active_on = q.idle_ph;
                    end
                    d.status = active_on;
                end
                if (flash_start) begin
                    d.left = NW'(NV_FLASHES);
                    d.slow = 1'b0;
                    d.status = 1'b1;
                    d.tmr = '0;
                    d.st = SLS_FLASH;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            q <= '0;
            q.st <= SLS_BOOT;
            q.poll <= POLL_DEFAULT;
        end else begin
            q <= d;
        end
    end

    assign led_status = q.status;
    assign led_pwr_good = q.pg;
    assign led_charging = q.chg;
    assign led_chg_done = q.done;

    // ---- checks ----
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    sequence good_boot_s;
        q.st == SLS_BOOT && boot_done && !radio_fault && !flash_fault;
    endsequence
    sequence radio_boot_s;
        q.st == SLS_BOOT && boot_done && radio_fault;
    endsequence

    boot_flash_a: assert property (good_boot_s |=> q.st == SLS_FLASH
        && q.left == NW'(BOOT_FLASHES) && led_status)
        else $error("good boot did not start ten flashes");
    boot_fault_a: assert property (radio_boot_s |=>
        q.st == SLS_FAULT && q.slow)
        else $error("faulted boot showed the good pattern");
    radio_four_a: assert property (radio_boot_s |=>
        q.left == NW'(RADIO_FLASHES))
        else $error("radio fault count wrong");
    flash_five_a: assert property (q.st == SLS_BOOT && boot_done
        && !radio_fault && flash_fault |=> q.left == NW'(FLASH_FLASHES))
        else $error("flash fault count wrong");
    steady_on_a: assert property (q.st == SLS_RUN && !q.nv_pend
        && !q.blip_pend && sess_log && !(sleep_mode && q.poll_cnt == '0)
        |=> led_status)
        else $error("session led not steady");
    ping_blip_a: assert property (q.st == SLS_RUN && !q.nv_pend
        && q.blip_pend |=> q.st == SLS_BLIP && led_status)
        else $error("ping blip missing");
    nv_flash_a: assert property (q.st == SLS_RUN && q.nv_pend
        |=> q.st == SLS_FLASH && q.left == NW'(NV_FLASHES))
        else $error("eeprom flash missing");
    poll_prog_a: assert property (poll_wr && poll_val != '0
        |=> q.poll == $past(poll_val))
        else $error("poll interval not taken");
    charge_led_a: assert property (q.s2 == 3'b110 |=> led_charging
        && !led_chg_done && led_pwr_good)
        else $error("charging indication wrong");
    done_led_a: assert property (!q.s2[2] |=>
        !led_chg_done && !led_charging)
        else $error("leds lit with supply removed");
    full_swap_a: assert property (q.s2 == 3'b111 |=>
        led_chg_done && !led_charging)
        else $error("full charge swap wrong");
    pwr_good_a: assert property (q.s2[2] |=> led_pwr_good)
        else $error("supply good led dark with supply present");
    done_full_a: assert property (!q.s2[0] |=> !led_chg_done)
        else $error("complete led lit before battery full");

    // the steady patterns only show when nothing pending overrides them
    sequence idle_run_s;
        q.st == SLS_RUN && !q.nv_pend && !q.blip_pend && !sleep_mode
        && !sess_log && !sess_stream && !sess_hs && !range_test
        && !sess_ldc;
    endsequence
    sequence range_run_s;
        q.st == SLS_RUN && !q.nv_pend && !q.blip_pend && range_test
        && !sess_log && !sess_stream && !sess_hs;
    endsequence
    sequence sleep_run_s;
        q.st == SLS_RUN && !q.nv_pend && !q.blip_pend && sleep_mode
        && q.poll_cnt == '0 && !sess_ldc && !range_test;
    endsequence
    // last cycle of a blip, whichever length it was given
    sequence blip_end_s;
        q.st == SLS_BLIP && q.tmr + TW'(1) >= q.blip_len;
    endsequence
    // last cycle of the final dark phase of a counted burst
    sequence flash_end_s;
        q.st == SLS_FLASH && q.left == '0 && !q.status
        && q.tmr + TW'(1) >= half_of(q.slow);
    endsequence

    idle_pulse_a: assert property (idle_run_s |=>
        led_status == $past(q.idle_ph))
        else $error("idle pulse does not follow its phase");
    range_fast_a: assert property (range_run_s |=>
        led_status == $past(q.rng_ph))
        else $error("range test blips do not follow their phase");
    sleep_blip_a: assert property (sleep_run_s |=>
        q.st == SLS_BLIP && q.blip_len == TW'(FAINT_LEN) && led_status)
        else $error("sleep poll blip missing");
    blip_end_a: assert property (blip_end_s |=>
        !led_status && q.st == SLS_RUN)
        else $error("blip did not end");
    burst_end_a: assert property (flash_end_s |=>
        q.st == SLS_RUN && !led_status)
        else $error("flash burst did not return to run");
    fault_dark_a: assert property (q.st == SLS_GAP |=>
        q.st == SLS_GAP && !led_status)
        else $error("led lit after fault blinks");
    boot_dark_a: assert property (q.st == SLS_BOOT && !boot_done
        |=> !led_status)
        else $error("led lit before boot outcome known");
    ping_latch_a: assert property (ping_evt |=> q.blip_pend)
        else $error("ping strobe lost");
    nv_latch_a: assert property (nv_evt |=> q.nv_pend)
        else $error("nonvolatile access strobe lost");
    // a faulted boot must never fall into the good burst
    fault_first_a: assert property (q.st == SLS_BOOT
        && boot_done && flash_fault |=> q.st == SLS_FAULT && q.slow)
        else $error("fault pattern lost priority");
endmodule

// ==== verification/sls_observer.sv ====
// sls_observer: faceplate viewer timing each status led flash
// assumes led_status is registered on clk_sys; reports once per fall
`timescale 1ns/1ns
module sls_observer (
    // clock
    input wire logic clk_sys,
    // watched led
    input wire logic led_status,
    // one report per flash: on time and fall-to-fall period in cycles
    output logic seen,
    output logic [31:0] on_len,
    output logic [31:0] period
);
    logic [31:0] hi_q = 0;
    logic [31:0] lo_q = 0;
    logic [31:0] lo_keep_q = 0;
    initial seen = 1'b0;
    // a human sees only edges, so nothing here looks at reset
    always @(posedge clk_sys) begin
        seen <= 1'b0;
        if (led_status) begin
            if (hi_q == 0)
                lo_keep_q <= lo_q;
            hi_q <= hi_q + 1;
        end else if (hi_q != 0) begin
            seen <= 1'b1;
            on_len <= hi_q;
            period <= hi_q + lo_keep_q;
            hi_q <= 0;
            lo_q <= 1;
        end else
            lo_q <= lo_q + 1;
    end
endmodule

// ==== verification/sls_status_led_tb.sv ====
// sls_status_led_tb: self-checking bench for the status led sequencer
// assumes shortened pattern times; the observer times each status flash
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
    failures++; $display("ERROR %s exp %0d got %0d", nm, e, g); end end
module sls_status_led_tb;
    import sls_pkg::*;
    localparam int FH = 4, SH = 8, BL = 3, FL = 2, RH = 2, IH = 40, PD = 30;
    logic clk_sys = 0, sys_rst = 1, boot_done = 0, radio_fault = 0;
    logic flash_fault = 0, sess_log = 0, sess_stream = 0, sess_hs = 0;
    logic sess_ldc = 0, range_test = 0, sleep_mode = 0, ldc_sample = 0;
    logic ping_evt = 0, nv_evt = 0, poll_wr = 0, ext_pwr_ok = 0;
    logic chg_active = 0, batt_full = 0, strict = 0;
    logic [TW-1:0] poll_val = '0;
    logic led_status, led_pwr_good, led_charging, led_chg_done, seen;
    logic [31:0] on_len, period;
    int failures = 0, checks_done = 0;
    // zero in a note means that figure is not judged
    logic [31:0] q_len[$], q_per[$];
    logic [7:0] rnd = 8'h2B;

    sls_status_led #(.IDLE_HALF(IH), .FAST_HALF(FH), .SLOW_HALF(SH),
        .BLIP_LEN(BL), .FAINT_LEN(FL), .RANGE_HALF(RH),
        .POLL_DEFAULT(TW'(PD))) sls_status_led_i (.clk_sys(clk_sys),
        .sys_rst(sys_rst), .boot_done(boot_done), .radio_fault(radio_fault),
        .flash_fault(flash_fault), .sess_log(sess_log),
        .sess_stream(sess_stream), .sess_hs(sess_hs), .sess_ldc(sess_ldc),
        .range_test(range_test), .sleep_mode(sleep_mode),
        .ldc_sample(ldc_sample), .ping_evt(ping_evt), .nv_evt(nv_evt),
        .poll_wr(poll_wr), .poll_val(poll_val), .ext_pwr_ok(ext_pwr_ok),
        .chg_active(chg_active), .batt_full(batt_full),
        .led_status(led_status), .led_pwr_good(led_pwr_good),
        .led_charging(led_charging), .led_chg_done(led_chg_done));
    sls_observer sls_observer_i (.clk_sys(clk_sys), .led_status(led_status),
        .seen(seen), .on_len(on_len), .period(period));

    initial forever #50 clk_sys = ~clk_sys;

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic note(input int n, input int len, input int per);
        repeat (n) begin
            q_len.push_back(len);
            q_per.push_back(per);
        end
    endtask
    task automatic drain();
        int t;
        t = 0;
        while (q_len.size() != 0 && t < 3000) begin
            cyc(1);
            t++;
        end
        `CHK("pending flashes", 0, q_len.size())
    endtask
    task automatic boot(input logic rf, input logic ff);
        sys_rst <= 1'b1;
        cyc(3);
        sys_rst <= 1'b0;
        boot_done <= 1'b1;
        radio_fault <= rf;
        flash_fault <= ff;
        cyc(1);
        boot_done <= 1'b0;
    endtask
    task automatic strobe(input int k);
        if (k == 0)
            ldc_sample <= 1'b1;
        else if (k == 1)
            ping_evt <= 1'b1;
        else
            nv_evt <= 1'b1;
        cyc(1);
        {ldc_sample, ping_evt, nv_evt} <= 3'b000;
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge clk_sys) begin
        if (seen && q_len.size() != 0) begin
            if (q_len[0] != 0) `CHK("flash length", q_len[0], on_len)
            if (q_per[0] != 0) `CHK("flash period", q_per[0], period)
            void'(q_len.pop_front());
            void'(q_per.pop_front());
        end else if (seen && strict)
            `CHK("unexpected flash", 32'd0, on_len)
    end

    // the whole run is under two thousand cycles
    initial begin
        cyc(40000);
        failures++;
        print_verdict();
    end

    initial begin
        // fault boots with a session requested: the fault blinks win
        strict <= 1'b1;
        sess_log <= 1'b1;
        note(1, SH, 0);
        note(3, SH, 2 * SH);
        boot(1'b1, 1'b1);
        drain();
        cyc(100);
        note(1, SH, 0);
        note(4, SH, 2 * SH);
        boot(1'b0, 1'b1);
        drain();
        cyc(100);
        strict <= 1'b0;
        sess_log <= 1'b0;
        note(1, FH, 0);
        note(9, FH, 2 * FH);
        note(1, 0, 0);
        note(2, IH, 2 * IH);
        boot(1'b0, 1'b0);
        drain();
        for (int s = 0; s < 3; s++) begin
            {sess_log, sess_stream, sess_hs} <= 3'(1 << s);
            cyc(3);
            repeat (50) begin
                cyc(1);
                `CHK("session steady", 1'b1, led_status)
            end
        end
        {sess_log, sess_stream, sess_hs} <= 3'b000;
        note(1, 0, 0);
        note(3, RH, 2 * RH);
        range_test <= 1'b1;
        drain();
        range_test <= 1'b0;
        // quiet low duty cycle backdrop, longer than an idle half period
        sess_ldc <= 1'b1;
        cyc(2 * IH);
        strict <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            note(1, k == 2 ? FH : BL, 0);
            if (k == 2)
                note(2, FH, 2 * FH);
            strobe(k);
            drain();
            cyc(20);
        end
        sess_ldc <= 1'b0;
        strict <= 1'b0;
        sleep_mode <= 1'b1;
        note(1, 0, 0);
        note(2, FL, PD);
        drain();
        poll_wr <= 1'b1;
        poll_val <= TW'(2 * PD);
        cyc(1);
        poll_wr <= 1'b0;
        note(1, 0, 0);
        note(2, FL, 2 * PD);
        drain();
        sleep_mode <= 1'b0;
        for (int i = 0; i < 24; i++) begin
            rnd = lfsr(rnd);
            {ext_pwr_ok, chg_active, batt_full} <= {rnd[2], rnd[2] & rnd[1],
                rnd[0]};
            cyc(4);
            `CHK("power good", rnd[2], led_pwr_good)
            `CHK("charging", rnd[2] & rnd[1] & ~rnd[0], led_charging)
            `CHK("charge done", rnd[2] & rnd[1] & rnd[0], led_chg_done)
        end
        print_verdict();
    end
endmodule
